// file: dv/timer8_compare_pwm_unit_properties.sv
// Port checker for the 8-bit compare/PWM timer.
// Bound to the top module; sees only its ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module timer8_checker #(
	parameter int DATA_W = 32
) (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic hsel_i, // Select
	input wire logic [31:0] haddr_i, // Address
	input wire logic [1:0] htrans_i, // Transfer type
	input wire logic hwrite_i, // Write
	input wire logic hready_i, // Bus ready
	input wire logic [DATA_W-1:0] hrdata_o, // Read data
	input wire logic hreadyout_o, // Slave ready
	input wire logic hresp_o, // Response
	input wire logic global_irq_enable_i, // Global enable
	input wire logic compare_vector_taken_i, // Compare vector
	input wire logic overflow_vector_taken_i, // Overflow vector
	input wire logic compare_irq_o, // Compare request
	input wire logic overflow_irq_o, // Overflow request
	input wire logic port_dir_i, // Direction
	input wire logic compare_output_oe_o // Driver enable
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence rd_take;
		hsel_i && hready_i && htrans_i[1] && !hwrite_i;
	endsequence
	sequence rd_at(a);
		rd_take ##0 (haddr_i == a);
	endsequence
	bus_okay_a: assert property (hreadyout_o && !hresp_o)
		else $error("bus not ready or not okay");
	rd_hold_a: assert property (!(hsel_i && hready_i && htrans_i[1] && !hwrite_i) |=> $stable(hrdata_o))
		else $error("read data moved without a read");
	unmapped_zero_a: assert property (rd_take ##0 (haddr_i > 32'h00000010) |=> hrdata_o == '0)
		else $error("unmapped read not zero");
	force_reads_zero_a: assert property (rd_at(timer8_pkg::OFS_CONTROL) |=> !hrdata_o[7])
		else $error("force bit read as one");
	mask_reserved_a: assert property (rd_at(timer8_pkg::OFS_IRQ_MASK) |=> hrdata_o[7:2] == 6'h00)
		else $error("reserved mask bits set");
	oe_follow_a: assert property (compare_output_oe_o == port_dir_i)
		else $error("driver enable differs from direction");
	cmp_irq_gate_a: assert property (compare_irq_o |-> global_irq_enable_i)
		else $error("compare request without global enable");
	ovf_irq_gate_a: assert property (overflow_irq_o |-> global_irq_enable_i)
		else $error("overflow request without global enable");
	cmp_vector_clear_a: assert property (compare_vector_taken_i && compare_irq_o |=> !compare_irq_o)
		else $error("compare flag kept after vector");
	ovf_vector_clear_a: assert property (overflow_vector_taken_i && overflow_irq_o |=> !overflow_irq_o)
		else $error("overflow flag kept after vector");
endmodule
bind timer8_compare_pwm_unit timer8_checker #(.DATA_W(DATA_W)) u_timer8_checker (.clk_i, .rst_i,
	.hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o,
	.global_irq_enable_i, .compare_vector_taken_i, .overflow_vector_taken_i, .compare_irq_o,
	.overflow_irq_o, .port_dir_i, .compare_output_oe_o);
`default_nettype wire

// file: dv/timer8_compare_pwm_unit_test.sv
// Self-checking bench for the compare/PWM timer, driven over AHB-Lite.
// Assumes the slave answers every phase at once; waits are still bounded.
`timescale 1ns/1ps
`default_nettype none
module timer8_compare_pwm_unit_test;
	localparam logic [31:0] C = timer8_pkg::OFS_CONTROL;
	localparam logic [31:0] N = timer8_pkg::OFS_COUNT;
	localparam logic [31:0] P = timer8_pkg::OFS_COMPARE;
	localparam logic [31:0] M = timer8_pkg::OFS_IRQ_MASK;
	localparam logic [31:0] F = timer8_pkg::OFS_IRQ_FLAGS;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic hsel_i = 1'b1;
	logic [31:0] haddr_i = '0;
	logic [1:0] htrans_i = 2'h0;
	logic hwrite_i = 1'b0;
	logic [31:0] hwdata_i = '0;
	logic [31:0] hrdata_o;
	logic hreadyout_o;
	logic global_irq_enable_i = 1'b0;
	logic compare_vector_taken_i = 1'b0;
	logic overflow_vector_taken_i = 1'b0;
	logic compare_irq_o;
	logic overflow_irq_o;
	logic external_count_pin_i = 1'b0;
	logic port_dir_i = 1'b1;
	logic port_data_i = 1'b0;
	logic compare_output_pin_o;
	logic compare_output_oe_o;
	int mismatches = 0;
	int check_count = 0;
	logic [7:0] v;
	int hi;
	int dv[5] = '{1, 8, 64, 256, 1024};
	logic [1:0] act[4] = '{2'h3, 2'h2, 2'h1, 2'h1};
	logic ex[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
	always #2 clk_i = ~clk_i;
	timer8_compare_pwm_unit u_timer8_compare_pwm_unit (.clk_i, .rst_i, .hsel_i, .haddr_i,
		.htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
		.hreadyout_o, .hresp_o(), .global_irq_enable_i, .compare_vector_taken_i,
		.overflow_vector_taken_i, .compare_irq_o, .overflow_irq_o, .external_count_pin_i,
		.port_dir_i, .port_data_i, .compare_output_pin_o, .compare_output_oe_o);
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] d);
		htrans_i <= 2'h2;
		haddr_i <= a;
		hwrite_i <= w;
		@(posedge clk_i);
		while (hreadyout_o !== 1'b1) @(posedge clk_i);
		htrans_i <= 2'h0;
		hwdata_i <= {24'h000000, d};
		@(posedge clk_i);
		while (hreadyout_o !== 1'b1) @(posedge clk_i);
		v = hrdata_o[7:0];
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		xfer(a, 1'b1, d);
	endtask
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic rc(input logic [31:0] a, input logic [7:0] e);
		xfer(a, 1'b0, 8'h00);
		check(v, e);
	endtask
	task automatic pulses(input int n);
		repeat (n) begin
			external_count_pin_i <= 1'b1;
			cyc(3);
			external_count_pin_i <= 1'b0;
			cyc(3);
		end
	endtask
	task automatic highs(input int n);
		hi = 0;
		repeat (n) begin
			@(posedge clk_i);
			if (compare_output_pin_o === 1'b1) hi++;
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (80000) @(posedge clk_i);
		mismatches++;
		wrap_up;
	end
	initial begin
		cyc(2);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int i = 0; i < 6; i++) rc(32'(i * 4), 8'h00);
		wr(M, 8'hFF);
		rc(M, 8'h03);
		wr(C, 8'h80);
		rc(C, 8'h00);
		$display("registers done");
		for (int i = 0; i < 5; i++) begin
			wr(N, 8'h00);
			wr(C, 8'(i + 1));
			cyc(20 * dv[i]);
			wr(C, 8'h00);
			xfer(N, 1'b0, 8'h00);
			check(v >= 8'd20 && v <= 8'd22, 1);
			cyc(10);
			rc(N, v);
		end
		$display("prescaler done");
		wr(N, 8'hF0);
		wr(F, 8'h03);
		wr(C, 8'h01);
		cyc(30);
		wr(C, 8'h00);
		rc(F, 8'h03);
		global_irq_enable_i <= 1'b1;
		wr(M, 8'h03);
		cyc(1);
		check({compare_irq_o, overflow_irq_o}, 2'h3);
		global_irq_enable_i <= 1'b0;
		cyc(1);
		check({compare_irq_o, overflow_irq_o}, 2'h0);
		global_irq_enable_i <= 1'b1;
		wr(M, 8'h01);
		cyc(1);
		check({compare_irq_o, overflow_irq_o}, 2'h1);
		wr(M, 8'h03);
		wr(F, 8'h02);
		rc(F, 8'h01);
		wr(F, 8'h00);
		rc(F, 8'h01);
		overflow_vector_taken_i <= 1'b1;
		cyc(1);
		overflow_vector_taken_i <= 1'b0;
		rc(F, 8'h00);
		$display("flags done");
		wr(P, 8'h05);
		wr(N, 8'h00);
		wr(C, 8'h41);
		cyc(40);
		wr(C, 8'h00);
		xfer(N, 1'b0, 8'h00);
		check(v <= 8'h05, 1);
		rc(F, 8'h02);
		compare_vector_taken_i <= 1'b1;
		cyc(1);
		compare_vector_taken_i <= 1'b0;
		rc(F, 8'h00);
		wr(N, 8'h03);
		for (int i = 0; i < 4; i++) begin
			wr(C, {2'h1, act[i], 4'h0});
			wr(C, {2'h3, act[i], 4'h0});
			cyc(1);
			check(compare_output_pin_o, ex[i]);
		end
		rc(N, 8'h03);
		rc(F, 8'h00);
		wr(C, 8'h40);
		port_data_i <= 1'b1;
		cyc(1);
		check(compare_output_pin_o, 1'b1);
		$display("compare actions done");
		wr(N, 8'h00);
		wr(C, 8'h07);
		pulses(5);
		wr(C, 8'h06);
		pulses(5);
		rc(N, 8'h0A);
		wr(P, 8'h07);
		wr(C, 8'h47);
		wr(F, 8'h03);
		wr(N, 8'h07);
		pulses(1);
		rc(N, 8'h08);
		rc(F, 8'h00);
		$display("external done");
		wr(P, 8'h80);
		wr(C, 8'h69);
		cyc(300);
		highs(512);
		check(hi >= 256 && hi <= 260, 1);
		rc(F, 8'h03);
		wr(P, 8'hFF);
		cyc(300);
		highs(300);
		check(hi, 300);
		wr(P, 8'h40);
		wr(C, 8'h29);
		cyc(600);
		wr(F, 8'h03);
		highs(510);
		check(hi >= 126 && hi <= 130, 1);
		rc(F, 8'h03);
		wr(C, 8'h00);
		$display("pwm done");
		wrap_up;
	end
endmodule
`default_nettype wire

// file: src/timer8_compare_pwm_unit.sv
// 8-bit timer/counter with one compare channel, four waveform modes, a
// prescaler, an external count input and overflow/compare flags.
// Assumes one 250 MHz clock, synchronous pin inputs and an AHB-Lite master.
//
// Behaviour
// - Force strobe makes immediate compare in non-PWM
// - Forced compare sets no flag, never clears
// - Force bit always reads back zero
// - Codes 0/2 normal/CTC, immediate compare update
// - Codes 1/3 phase/fast PWM, update at top
// - Nonzero action overrides pin; direction enables driver
// - Non-PWM actions: off, toggle, clear, set
// - Fast PWM: clear/set on match, opposite top
// - Phase PWM: action by count direction
// - Compare equal top: act at top instead
// - Clock select: stop, divide 1/8/64/256/1024
// - External pin edges count, even as output
// - Counter writable; write blocks next match
// - Continuous compare sets flag, drives output
// - Compare irq needs enable, global, flag
// - Overflow irq needs enable, global, flag
// - Flags cleared by vector or writing one
// - Phase PWM overflow at direction change bottom
// - Mask bits 7..2 reserved, read zero
// - Fast PWM wraps MAX to zero
// - Phase PWM holds MAX one tick, reverses
`timescale 1ns/1ps
`default_nettype none

module timer8_compare_pwm_unit #(
	parameter int DATA_W = 32
) (
	input wire logic clk_i, // I/O clock, 250 MHz
	input wire logic rst_i, // Asynchronous reset, active high
	input wire logic hsel_i, // AHB slave select
	input wire logic [31:0] haddr_i, // AHB address
	input wire logic [1:0] htrans_i, // AHB transfer type
	input wire logic hwrite_i, // AHB write
	input wire logic [2:0] hsize_i, // AHB size, word only
	input wire logic [DATA_W-1:0] hwdata_i, // AHB write data
	input wire logic hready_i, // AHB bus ready
	output logic [DATA_W-1:0] hrdata_o, // AHB read data
	output logic hreadyout_o, // AHB slave ready
	output logic hresp_o, // AHB response
	input wire logic global_irq_enable_i, // Global interrupt enable of the core
	input wire logic compare_vector_taken_i, // Pulse: compare vector executed
	input wire logic overflow_vector_taken_i, // Pulse: overflow vector executed
	output logic compare_irq_o, // Compare interrupt request
	output logic overflow_irq_o, // Overflow interrupt request
	input wire logic external_count_pin_i, // External count input level
	input wire logic port_dir_i, // Data direction bit of the shared pin
	input wire logic port_data_i, // Normal port value of the shared pin
	output logic compare_output_pin_o, // Shared pin output value
	output logic compare_output_oe_o // Shared pin driver enable
);

	// The block keeps all timer state in this one clock domain.
	// Pin inputs arrive already synchronous, so no extra stages are added.
	// Registers hold only the live fields; reserved bits are not stored.
	// Bus side state
	logic wr_pend;
	logic [31:0] wr_addr;
	logic [DATA_W-1:0] rdata;

	// Registers
	logic [1:0] wave_sel;
	logic [1:0] action;
	logic [2:0] clk_sel;
	logic [7:0] count;
	logic [7:0] compare_buf;
	logic [7:0] compare_active;
	logic cmp_irq_en;
	logic ovf_irq_en;
	logic cmp_flag;
	logic ovf_flag;

	// Timing state
	logic [timer8_pkg::PRESCALE_W-1:0] prescale;
	logic ext_prev;
	logic count_down;
	logic match_blocked;
	logic oc_state;

	// Next values
	logic [7:0] next_count;
	logic next_down;
	logic next_oc;
	logic [DATA_W-1:0] read_value;

	function automatic logic tap_hit(input logic [9:0] cnt, input logic [9:0] mask);
		tap_hit = (cnt & mask) == mask;
	endfunction

	function automatic logic non_pwm_action(input logic cur, input logic [1:0] act);
		non_pwm_action = cur;
		if (act == timer8_pkg::ACT_TOGGLE) begin
			non_pwm_action = ~cur;
		end else if (act == timer8_pkg::ACT_CLEAR) begin
			non_pwm_action = 1'b0;
		end else if (act == timer8_pkg::ACT_SET) begin
			non_pwm_action = 1'b1;
		end
	endfunction

	// ---------------- AHB-Lite slave ----------------
	// Writes land at the edge that ends the data phase.
	// Reads capture a snapshot at the address-phase edge, so the
	// counter value returned is the one seen when the address was taken.
	// Only the low byte of the write data is used; the rest is ignored.
	// Zero wait states: every transfer completes in its first data phase.
	wire addr_phase = hsel_i && hready_i && htrans_i[timer8_pkg::HTRANS_ACTIVE_BIT];
	wire wr_control = wr_pend && (wr_addr == timer8_pkg::OFS_CONTROL);
	wire wr_count = wr_pend && (wr_addr == timer8_pkg::OFS_COUNT);
	wire wr_compare = wr_pend && (wr_addr == timer8_pkg::OFS_COMPARE);
	wire wr_mask = wr_pend && (wr_addr == timer8_pkg::OFS_IRQ_MASK);
	wire wr_flags = wr_pend && (wr_addr == timer8_pkg::OFS_IRQ_FLAGS);
	wire [7:0] wdata8 = hwdata_i[7:0];

	always_comb begin
		read_value = {DATA_W{1'b0}};
		if (haddr_i == timer8_pkg::OFS_CONTROL) begin
			read_value[7:0] = {1'b0, wave_sel[1], action, wave_sel[0], clk_sel};
		end else if (haddr_i == timer8_pkg::OFS_COUNT) begin
			read_value[7:0] = count;
		end else if (haddr_i == timer8_pkg::OFS_COMPARE) begin
			read_value[7:0] = compare_buf;
		end else if (haddr_i == timer8_pkg::OFS_IRQ_MASK) begin
			read_value[7:0] = {6'h00, cmp_irq_en, ovf_irq_en};
		end else if (haddr_i == timer8_pkg::OFS_IRQ_FLAGS) begin
			read_value[7:0] = {6'h00, cmp_flag, ovf_flag};
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_pend <= 1'b0;
			wr_addr <= timer8_pkg::WORD_ZERO;
			rdata <= {DATA_W{1'b0}};
		end else begin
			wr_pend <= addr_phase && hwrite_i;
			if (addr_phase) begin
				wr_addr <= haddr_i;
			end
			if (addr_phase && !hwrite_i) begin
				rdata <= read_value;
			end
		end
	end

	assign hrdata_o = rdata;
	assign hreadyout_o = 1'b1;
	assign hresp_o = timer8_pkg::HRESP_OKAY;

	// ---------------- Mode decode ----------------
	// Both PWM modes share the buffered compare and the reserved action code.
	// Normal and clear-on-match use the compare value at once.
	wire is_pwm = (wave_sel == timer8_pkg::WAVE_PHASE) || (wave_sel == timer8_pkg::WAVE_FAST);
	wire is_fast = wave_sel == timer8_pkg::WAVE_FAST;
	wire is_phase = wave_sel == timer8_pkg::WAVE_PHASE;
	wire is_ctc = wave_sel == timer8_pkg::WAVE_CTC;

	// ---------------- Clock select ----------------
	// Every slower rate is a one-cycle enable, never a derived clock.
	// Switching taps mid-period may shorten the first period; software
	// that needs exact timing should restart the counter after a change.
	// The prescaler runs freely so that taps stay aligned between selections.
	wire ext_rise = external_count_pin_i && !ext_prev;
	wire ext_fall = !external_count_pin_i && ext_prev;
	logic tick;

	always_comb begin
		tick = 1'b0;
		case (clk_sel)
			timer8_pkg::CS_DIV1: tick = 1'b1;
			timer8_pkg::CS_DIV8: tick = tap_hit(prescale, timer8_pkg::PRE_MASK_8);
			timer8_pkg::CS_DIV64: tick = tap_hit(prescale, timer8_pkg::PRE_MASK_64);
			timer8_pkg::CS_DIV256: tick = tap_hit(prescale, timer8_pkg::PRE_MASK_256);
			timer8_pkg::CS_DIV1024: tick = tap_hit(prescale, timer8_pkg::PRE_MASK_1024);
			timer8_pkg::CS_EXT_FALL: tick = ext_fall;
			timer8_pkg::CS_EXT_RISE: tick = ext_rise;
			default: tick = 1'b0;
		endcase
	end

	// ---------------- Compare and events ----------------
	// A counter write in the same cycle wins over a tick, so no event fires then.
	wire run_tick = tick && !wr_count;
	wire equal = count == compare_active;
	wire match_event = run_tick && equal && !match_blocked;
	wire at_max = count == timer8_pkg::COUNT_MAX;
	wire at_bottom = count == timer8_pkg::COUNT_BOTTOM;
	wire top_event = run_tick && at_max && is_pwm && (is_fast || !count_down);
	wire special_top = is_pwm && action[1] && (compare_active == timer8_pkg::COUNT_MAX);
	wire ovf_phase = is_phase && count_down && at_bottom;
	wire ovf_event = run_tick && ((!is_phase && at_max) || ovf_phase);
	// Force only acts outside PWM and never reaches flags or the counter.
	wire force_event = wr_control && wdata8[timer8_pkg::FORCE_BIT] && !is_pwm;

	// ---------------- Counter sequencing ----------------
	// A software write always wins over counting in the same cycle.
	// Phase mode holds the direction bit; other modes force it to up.
	// Clear-on-match uses the unblocked match so a fresh write is not cut.
	always_comb begin
		next_count = count;
		next_down = count_down;
		if (!is_phase) begin
			next_down = 1'b0;
		end
		if (wr_count) begin
			next_count = wdata8;
		end else if (tick) begin
			case (wave_sel)
				timer8_pkg::WAVE_NORMAL: begin
					next_count = count + timer8_pkg::COUNT_ONE;
				end
				timer8_pkg::WAVE_CTC: begin
					if (equal && !match_blocked) begin
						next_count = timer8_pkg::COUNT_BOTTOM;
					end else begin
						next_count = count + timer8_pkg::COUNT_ONE;
					end
				end
				timer8_pkg::WAVE_FAST: begin
					next_count = count + timer8_pkg::COUNT_ONE;
				end
				default: begin
					if (!count_down && at_max) begin
						next_down = 1'b1;
						next_count = count - timer8_pkg::COUNT_ONE;
					end else if (count_down && at_bottom) begin
						next_down = 1'b0;
						next_count = count + timer8_pkg::COUNT_ONE;
					end else if (count_down) begin
						next_count = count - timer8_pkg::COUNT_ONE;
					end else begin
						next_count = count + timer8_pkg::COUNT_ONE;
					end
				end
			endcase
		end
	end

	// ---------------- Waveform output ----------------
	// The force strobe uses the action held before the same write, so
	// software must set the action first and force in a later write.
	// With the compare at top in PWM, the top action replaces the match so
	// the output stays at a constant level instead of glitching.
	always_comb begin
		next_oc = oc_state;
		if (force_event) begin
			next_oc = non_pwm_action(oc_state, action);
		end else if (!is_pwm) begin
			if (match_event) begin
				next_oc = non_pwm_action(oc_state, action);
			end
		end else if (action[1]) begin
			// Action 01 in PWM modes is reserved and leaves the output alone.
			if (top_event && (is_fast || special_top)) begin
				next_oc = ~action[0];
			end else if (match_event && !special_top) begin
				if (is_phase && count_down) begin
					next_oc = ~action[0];
				end else begin
					next_oc = action[0];
				end
			end
		end
	end

	assign compare_output_pin_o = (action != timer8_pkg::ACT_OFF) ? oc_state : port_data_i;
	assign compare_output_oe_o = port_dir_i;

	// ---------------- Interrupts out ----------------
	// Requests are plain gates of the stored flags; no extra latency.
	// A vector pulse clears its flag unless a new event sets it again.
	assign compare_irq_o = cmp_flag && cmp_irq_en && global_irq_enable_i;
	assign overflow_irq_o = ovf_flag && ovf_irq_en && global_irq_enable_i;

	wire cmp_clear = (wr_flags && wdata8[timer8_pkg::CMP_BIT]) || compare_vector_taken_i;
	wire ovf_clear = (wr_flags && wdata8[timer8_pkg::OVF_BIT]) || overflow_vector_taken_i;

	// ---------------- Register state ----------------
	// Reset leaves the timer stopped in normal mode with the pin released.
	// The force bit is a strobe and is never stored.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wave_sel <= timer8_pkg::WAVE_NORMAL;
			action <= timer8_pkg::ACT_OFF;
			clk_sel <= timer8_pkg::CS_STOP;
			cmp_irq_en <= 1'b0;
			ovf_irq_en <= 1'b0;
		end else begin
			if (wr_control) begin
				wave_sel <= {wdata8[timer8_pkg::WAVE_HI_BIT], wdata8[timer8_pkg::WAVE_LO_BIT]};
				action <= wdata8[timer8_pkg::ACTION_HI_BIT:timer8_pkg::ACTION_LO_BIT];
				clk_sel <= wdata8[timer8_pkg::CLKSEL_HI_BIT:timer8_pkg::CLKSEL_LO_BIT];
			end
			if (wr_mask) begin
				cmp_irq_en <= wdata8[timer8_pkg::CMP_BIT];
				ovf_irq_en <= wdata8[timer8_pkg::OVF_BIT];
			end
		end
	end

	// Compare buffer: immediate outside PWM, loaded at top in PWM modes.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			compare_buf <= timer8_pkg::REG8_RESET;
			compare_active <= timer8_pkg::REG8_RESET;
		end else begin
			if (wr_compare) begin
				compare_buf <= wdata8;
			end
			if (!is_pwm) begin
				compare_active <= wr_compare ? wdata8 : compare_buf;
			end else if (run_tick && at_max) begin
				compare_active <= compare_buf;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count <= timer8_pkg::REG8_RESET;
			count_down <= 1'b0;
			prescale <= timer8_pkg::PRE_ZERO;
			ext_prev <= 1'b0;
			oc_state <= 1'b0;
		end else begin
			count <= next_count;
			count_down <= next_down;
			prescale <= prescale + timer8_pkg::PRE_ONE;
			ext_prev <= external_count_pin_i;
			oc_state <= next_oc;
		end
	end

	// The block holds until the next timer tick that follows the write.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			match_blocked <= 1'b0;
		end else if (wr_count) begin
			match_blocked <= 1'b1;
		end else if (tick) begin
			match_blocked <= 1'b0;
		end
	end

	// Hardware set wins over any clear in the same cycle.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmp_flag <= 1'b0;
			ovf_flag <= 1'b0;
		end else begin
			cmp_flag <= match_event || (cmp_flag && !cmp_clear);
			ovf_flag <= ovf_event || (ovf_flag && !ovf_clear);
		end
	end

endmodule

`default_nettype wire

// file: src/timer8_pkg.sv
// Constants shared by the 8-bit compare/PWM timer: register map, field layout,
// mode and clock-select codes, prescaler taps and reset values.
// Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
package timer8_pkg;

	// Register byte offsets
	localparam logic [31:0] OFS_CONTROL = 32'h00000000;
	localparam logic [31:0] OFS_COUNT = 32'h00000004;
	localparam logic [31:0] OFS_COMPARE = 32'h00000008;
	localparam logic [31:0] OFS_IRQ_MASK = 32'h0000000C;
	localparam logic [31:0] OFS_IRQ_FLAGS = 32'h00000010;

	// timer_control_a field positions
	localparam int FORCE_BIT = 7;
	localparam int WAVE_HI_BIT = 6;
	localparam int ACTION_HI_BIT = 5;
	localparam int ACTION_LO_BIT = 4;
	localparam int WAVE_LO_BIT = 3;
	localparam int CLKSEL_HI_BIT = 2;
	localparam int CLKSEL_LO_BIT = 0;

	// Mask and flag bit positions
	localparam int CMP_BIT = 1;
	localparam int OVF_BIT = 0;

	// waveform_mode_sel codes
	localparam logic [1:0] WAVE_NORMAL = 2'h0;
	localparam logic [1:0] WAVE_PHASE = 2'h1;
	localparam logic [1:0] WAVE_CTC = 2'h2;
	localparam logic [1:0] WAVE_FAST = 2'h3;

	// compare_output_action codes
	localparam logic [1:0] ACT_OFF = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;

	// clock_source_sel codes
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;

	// Prescaler tap masks (divide by mask + 1)
	localparam int PRESCALE_W = 10;
	localparam logic [9:0] PRE_ZERO = 10'h000;
	localparam logic [9:0] PRE_ONE = 10'h001;
	localparam logic [9:0] PRE_MASK_8 = 10'h007;
	localparam logic [9:0] PRE_MASK_64 = 10'h03F;
	localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
	localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;

	// Counter landmarks and reset values
	localparam logic [7:0] COUNT_MAX = 8'hFF;
	localparam logic [7:0] COUNT_BOTTOM = 8'h00;
	localparam logic [7:0] COUNT_ONE = 8'h01;
	localparam logic [7:0] REG8_RESET = 8'h00;
	localparam logic [31:0] WORD_ZERO = 32'h00000000;

	// AHB-Lite encodings
	localparam int HTRANS_ACTIVE_BIT = 1;
	localparam logic HRESP_OKAY = 1'b0;

endpackage
